// >>> sec_map.svh
// address map, field positions and sizes of the sram ecc controller
`ifndef SEC_MAP_SVH
`define SEC_MAP_SVH

// array geometry
`define SEC_SRAM_BASE     32'h2000_0000
`define SEC_WORDS         1536
`define SEC_IDX_W         11
`define SEC_LAST_IDX      11'h5FF
`define SEC_OFF_W         13
`define SEC_DATA_W        32
`define SEC_CHK_W         7
`define SEC_CW_W          39
`define SEC_FULL_BE       4'hF
`define SEC_LOC_W         16

// register byte addresses
`define SEC_CTRL_ADDR     32'h4000_202C
`define SEC_ERR_ADDR      32'h4000_2030
`define SEC_STAT_ADDR     32'h4000_2034
`define SEC_MASK_ADDR     32'h4000_2038

// register select one-hot positions
`define SEC_SEL_W         4
`define SEC_SEL_CTRL      0
`define SEC_SEL_ERR       1
`define SEC_SEL_STAT      2
`define SEC_SEL_MASK      3

// sram_control fields
`define SEC_CTRL_ONE      0
`define SEC_CTRL_SBIE     1
`define SEC_CTRL_INIT     2
`define SEC_CTRL_DONE     15
`define SEC_CTRL_RESET    16'h0001

// interrupt status and mask fields
`define SEC_ST_W          3
`define SEC_ST_SBE        0
`define SEC_ST_DBE        1
`define SEC_ST_DONE       2

`endif

// >>> sec_pkg.sv
// types of the sram ecc controller
`default_nettype none
`include "sec_map.svh"
package sec_pkg;

  typedef enum logic [4:0] {
    ST_SCAN = 5'h01,
    ST_FILL = 5'h02,
    ST_IDLE = 5'h04,
    ST_READ = 5'h08,
    ST_DONE = 5'h10
  } sec_state_type;

  typedef struct packed {
    sec_state_type             state;
    logic                      scan_chk;
    logic                      bad;
    logic                      from_scan;
    logic [`SEC_IDX_W-1:0]     idx;
    logic [`SEC_IDX_W-1:0]     word;
    logic                      we;
    logic [3:0]                be;
    logic [`SEC_DATA_W-1:0]    wdata;
    logic [`SEC_DATA_W-1:0]    rdata;
    logic                      sbie;
    logic                      init_en;
    logic                      init_done;
    logic [`SEC_LOC_W-1:0]     err_loc;
    logic [`SEC_ST_W-1:0]      stat;
    logic [`SEC_ST_W-1:0]      mask;
    logic [31:0]               prdata;
    logic                      swrst;
  } sec_regs_type;

endpackage
`default_nettype wire

// >>> sec_ecc_if.sv
// link between the controller and its ecc codec
`timescale 1ns/1ps
`default_nettype none
`include "sec_map.svh"
interface sec_ecc_if;
  logic [`SEC_DATA_W-1:0] enc_data;
  logic [`SEC_CW_W-1:0]   enc_cw;
  logic [`SEC_CW_W-1:0]   dec_cw;
  logic [`SEC_DATA_W-1:0] dec_data;
  logic                   dec_single;
  logic                   dec_double;

  modport codec (input enc_data, dec_cw, output enc_cw, dec_data, dec_single, dec_double);
  modport user  (output enc_data, dec_cw, input enc_cw, dec_data, dec_single, dec_double);
endinterface
`default_nettype wire

// >>> sec_ecc_codec.sv
// secded (39,32) hamming encoder and decoder
`timescale 1ns/1ps
`default_nettype none
`include "sec_map.svh"
module sec_ecc_codec (
  sec_ecc_if.codec cx
);

  logic [`SEC_CW_W-1:0] cw;
  logic [`SEC_CW_W-1:0] fixed;
  logic [5:0]           syn;
  logic                 par;
  logic                 acc;
  int                   j;
  int                   jd;

  // encoder: data in non power-of-two slots, six hamming bits, overall parity in bit 0
  always_comb begin
    cw  = '0;
    j   = 0;
    acc = 1'b0;
    for (int k = 1; k < `SEC_CW_W; k++) begin
      if ((k & (k - 1)) != 0) begin
        cw[k] = cx.enc_data[j];
        j     = j + 1;
      end
    end
    for (int p = 0; p < 6; p++) begin
      acc = 1'b0;
      for (int k = 1; k < `SEC_CW_W; k++) begin
        if (((k >> p) & 1) != 0) begin
          acc = acc ^ cw[k];
        end
      end
      cw[1 << p] = acc;
    end
    cw[0]     = ^cw[`SEC_CW_W-1:1];
    cx.enc_cw = cw;
  end

  // decoder: syndrome locates a single flip, overall parity tells one from two
  always_comb begin
    syn   = 6'h00;
    jd    = 0;
    par   = ^cx.dec_cw;
    fixed = cx.dec_cw;
    cx.dec_data = '0;
    for (int k = 1; k < `SEC_CW_W; k++) begin
      if (cx.dec_cw[k]) begin
        syn = syn ^ 6'(k);
      end
    end
    cx.dec_single = par && (syn < 6'(`SEC_CW_W));
    cx.dec_double = (!par && (syn != 6'h00)) || (par && (syn >= 6'(`SEC_CW_W)));
    if (cx.dec_single) begin
      fixed[syn] = ~cx.dec_cw[syn];
    end
    for (int k = 1; k < `SEC_CW_W; k++) begin
      if ((k & (k - 1)) != 0) begin
        cx.dec_data[jd] = fixed[k];
        jd = jd + 1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> sec_sram_ecc_controller.sv
// sram with secded protection, scan and zero-fill sequencer, apb registers
// Function
// - 1536-word sram at 0x2000_0000, data and code
// - seven check bits, correct one, detect two
// - single-error interrupt only while control bit 1
// - reset scan; double error zero-fills, then soft reset
// - bit 15 set once zero-fill is complete
// - bit 2 starts zero-fill, clears by itself
// - bit 1 resets low, software sets or clears
// - control bits 14 to 3 read zero
// - faulty access offset loads error location register
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sec_map.svh"
module sec_sram_ecc_controller (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   mem_req,
  input  wire logic                   mem_we,
  input  wire logic [3:0]             mem_be,
  input  wire logic [`SEC_OFF_W-1:0]  mem_addr,
  input  wire logic [`SEC_DATA_W-1:0] mem_wdata,
  output logic                        mem_ready,
  output logic [`SEC_DATA_W-1:0]      mem_rdata,
  output logic                        irq,
  output logic                        soft_reset_req
);

  localparam sec_pkg::sec_regs_type RST = '{
    state: sec_pkg::ST_SCAN, scan_chk: 1'h0, bad: 1'h0, from_scan: 1'h0,
    idx: '0, word: '0, we: 1'h0, be: 4'h0, wdata: '0, rdata: '0,
    sbie: 1'h0, init_en: 1'h0, init_done: 1'h0, err_loc: '0,
    stat: '0, mask: '0, prdata: 32'h0000_0000, swrst: 1'h0
  };

  sec_pkg::sec_regs_type r;
  sec_pkg::sec_regs_type next_r;

  logic [`SEC_CW_W-1:0]   mem [0:`SEC_WORDS-1];
  logic [`SEC_CW_W-1:0]   mem_q;
  logic                   wr_en;
  logic [`SEC_IDX_W-1:0]  wr_idx;
  logic [`SEC_CW_W-1:0]   wr_cw;
  logic [`SEC_IDX_W-1:0]  rd_idx;
  logic [`SEC_SEL_W-1:0]  sel;
  logic                   apb_wr;
  logic                   apb_setup;
  logic                   ev_sbe;
  logic                   ev_dbe;
  logic                   ev_done;
  logic [`SEC_DATA_W-1:0] merged;
  logic [15:0]            ctrl_val;

  sec_ecc_if cx ();

  sec_ecc_codec u_codec (
    .cx (cx.codec)
  );

  // register decode, shared by the read and write paths
  function automatic logic [`SEC_SEL_W-1:0] reg_sel(input logic [31:0] a);
    logic [`SEC_SEL_W-1:0] s;
    s = '0;
    if (a == `SEC_CTRL_ADDR) begin
      s[`SEC_SEL_CTRL] = 1'h1;
    end else if (a == `SEC_ERR_ADDR) begin
      s[`SEC_SEL_ERR] = 1'h1;
    end else if (a == `SEC_STAT_ADDR) begin
      s[`SEC_SEL_STAT] = 1'h1;
    end else if (a == `SEC_MASK_ADDR) begin
      s[`SEC_SEL_MASK] = 1'h1;
    end
    return s;
  endfunction

  // apb handshake: zero-wait access phase, error on unmapped address
  assign sel       = reg_sel(paddr);
  assign apb_wr    = psel && penable && pwrite;
  assign apb_setup = psel && !penable;
  assign pready    = psel && penable;
  assign pslverr   = psel && penable && (sel == '0);

  // outputs
  assign prdata         = r.prdata;
  assign mem_rdata      = r.rdata;
  assign mem_ready      = (r.state == sec_pkg::ST_DONE);
  assign soft_reset_req = r.swrst;
  assign irq            = |(r.stat & r.mask);
  assign cx.dec_cw      = mem_q;

  // control register image: bit 0 always one, reserved bits zero
  always_comb begin
    ctrl_val = 16'h0000;
    ctrl_val[`SEC_CTRL_ONE]  = 1'h1;
    ctrl_val[`SEC_CTRL_SBIE] = r.sbie;
    ctrl_val[`SEC_CTRL_INIT] = r.init_en;
    ctrl_val[`SEC_CTRL_DONE] = r.init_done;
  end

  // byte merge of a partial write into the corrected stored word
  always_comb begin
    merged = cx.dec_data;
    for (int b = 0; b < 4; b++) begin
      if (r.be[b]) begin
        merged[b*8 +: 8] = r.wdata[b*8 +: 8];
      end
    end
  end

  // next-state logic
  always_comb begin
    next_r      = r;
    next_r.swrst = 1'h0;
    wr_en       = 1'h0;
    wr_idx      = r.idx;
    wr_cw       = '0;
    rd_idx      = r.idx;
    cx.enc_data = r.wdata;
    ev_sbe      = 1'h0;
    ev_dbe      = 1'h0;
    ev_done     = 1'h0;
    case (r.state)
      sec_pkg::ST_SCAN: begin
        // one cycle to read, one to check each word
        if (!r.scan_chk) begin
          next_r.scan_chk = 1'h1;
        end else begin
          next_r.scan_chk = 1'h0;
          if (cx.dec_double) begin
            next_r.bad = 1'h1;
          end
          if (r.idx == `SEC_LAST_IDX) begin
            next_r.idx = '0;
            if (r.bad || cx.dec_double) begin
              next_r.state     = sec_pkg::ST_FILL;
              next_r.from_scan = 1'h1;
              next_r.init_done = 1'h0;
            end else begin
              next_r.state = sec_pkg::ST_IDLE;
            end
          end else begin
            next_r.idx = r.idx + 11'h001;
          end
        end
      end
      sec_pkg::ST_FILL: begin
        // zero data has an all-zero codeword, so the fill writes valid check bits
        wr_en  = 1'h1;
        wr_idx = r.idx;
        wr_cw  = '0;
        if (r.idx == `SEC_LAST_IDX) begin
          next_r.state     = sec_pkg::ST_IDLE;
          next_r.idx       = '0;
          next_r.init_en   = 1'h0;
          next_r.init_done = 1'h1;
          next_r.swrst     = r.from_scan;
          next_r.from_scan = 1'h0;
          next_r.bad       = 1'h0;
          ev_done          = 1'h1;
        end else begin
          next_r.idx = r.idx + 11'h001;
        end
      end
      sec_pkg::ST_IDLE: begin
        rd_idx = mem_addr[`SEC_OFF_W-1:2];
        if (r.init_en) begin
          next_r.state     = sec_pkg::ST_FILL;
          next_r.idx       = '0;
          next_r.init_done = 1'h0;
        end else if (mem_req) begin
          next_r.word  = mem_addr[`SEC_OFF_W-1:2];
          next_r.we    = mem_we;
          next_r.be    = mem_be;
          next_r.wdata = mem_wdata;
          if (mem_addr[`SEC_OFF_W-1:2] > `SEC_LAST_IDX) begin
            next_r.rdata = '0;
            next_r.state = sec_pkg::ST_DONE;
          end else if (mem_we && (mem_be == `SEC_FULL_BE)) begin
            cx.enc_data  = mem_wdata;
            wr_en        = 1'h1;
            wr_idx       = mem_addr[`SEC_OFF_W-1:2];
            wr_cw        = cx.enc_cw;
            next_r.state = sec_pkg::ST_DONE;
          end else begin
            next_r.state = sec_pkg::ST_READ;
          end
        end
      end
      sec_pkg::ST_READ: begin
        rd_idx = r.word;
        ev_sbe = cx.dec_single;
        ev_dbe = cx.dec_double;
        if (cx.dec_single || cx.dec_double) begin
          next_r.err_loc = {3'h0, r.word, 2'h0};
        end
        if (r.we) begin
          cx.enc_data = merged;
          wr_en       = 1'h1;
          wr_idx      = r.word;
          wr_cw       = cx.enc_cw;
        end else begin
          next_r.rdata = cx.dec_data;
        end
        next_r.state = sec_pkg::ST_DONE;
      end
      sec_pkg::ST_DONE: begin
        next_r.state = sec_pkg::ST_IDLE;
      end
      default: begin
        next_r.state = sec_pkg::ST_IDLE;
      end
    endcase
    // software writes
    if (apb_wr && sel[`SEC_SEL_CTRL]) begin
      next_r.sbie = pwdata[`SEC_CTRL_SBIE];
      if (pwdata[`SEC_CTRL_INIT]) begin
        next_r.init_en = 1'h1;
      end
    end
    if (apb_wr && sel[`SEC_SEL_STAT]) begin
      next_r.stat = r.stat & ~pwdata[`SEC_ST_W-1:0];
    end
    if (apb_wr && sel[`SEC_SEL_MASK]) begin
      next_r.mask = pwdata[`SEC_ST_W-1:0];
    end
    // sticky events, set wins over a clear in the same cycle
    if (ev_sbe && r.sbie) begin
      next_r.stat[`SEC_ST_SBE] = 1'h1;
    end
    if (ev_dbe) begin
      next_r.stat[`SEC_ST_DBE] = 1'h1;
    end
    if (ev_done) begin
      next_r.stat[`SEC_ST_DONE] = 1'h1;
    end
    // read data captured in the setup phase
    if (apb_setup) begin
      next_r.prdata = 32'h0000_0000;
      if (sel[`SEC_SEL_CTRL]) begin
        next_r.prdata[15:0] = ctrl_val;
      end else if (sel[`SEC_SEL_ERR]) begin
        next_r.prdata[`SEC_LOC_W-1:0] = r.err_loc;
      end else if (sel[`SEC_SEL_STAT]) begin
        next_r.prdata[`SEC_ST_W-1:0] = r.stat;
      end else if (sel[`SEC_SEL_MASK]) begin
        next_r.prdata[`SEC_ST_W-1:0] = r.mask;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= RST;
    end else begin
      r <= next_r;
    end
  end

  // storage array, registered read port; contents survive reset; plain always leaves it open to fault seeding
  always @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_cw;
    end
    mem_q <= mem[rd_idx];
  end

  // cycles spent with a zero-fill pending outside the reset scan
  logic [11:0] init_cnt;
  localparam int FILL_BOUND = 1545;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_cnt <= 12'h000;
    end else if (r.init_en && (r.state != sec_pkg::ST_SCAN)) begin
      init_cnt <= init_cnt + 12'h001;
    end else begin
      init_cnt <= 12'h000;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sbe_gate: assert property ($rose(r.stat[`SEC_ST_SBE]) |-> $past(r.sbie) && $past(ev_sbe))
    else $error("single error flag set while its enable was low");

  a_ctrl_image: assert property (apb_setup && sel[`SEC_SEL_CTRL] |=>
    (prdata[14:3] == 12'h000) && prdata[`SEC_CTRL_ONE] && (prdata[31:16] == 16'h0000))
    else $error("control read shows wrong reserved bits");

  a_init_selfclr: assert property (init_cnt <= FILL_BOUND)
    else $error("initialisation enable did not clear by itself");

  a_done_on_end: assert property ($fell(r.init_en) |-> r.init_done && r.stat[`SEC_ST_DONE])
    else $error("fill ended without completion flag");

  a_done_clr_start: assert property ($rose(r.state == sec_pkg::ST_FILL) |-> !r.init_done)
    else $error("completion flag high while fill runs");

  a_err_loc_load: assert property ((r.state == sec_pkg::ST_READ) &&
    (cx.dec_single || cx.dec_double) |=> r.err_loc == {3'h0, $past(r.word), 2'h0})
    else $error("error location not loaded with access offset");

  a_read_fixed: assert property ((r.state == sec_pkg::ST_READ) && !r.we
    |=> mem_ready && (mem_rdata == $past(cx.dec_data)))
    else $error("read did not return decoded word");

  a_req_answer: assert property ((r.state == sec_pkg::ST_IDLE) && !r.init_en && mem_req
    |-> ##[1:2] mem_ready)
    else $error("memory request not answered in time");

  a_fill_zero: assert property ((r.state == sec_pkg::ST_FILL) |-> wr_en && (wr_cw == '0))
    else $error("fill did not write zero codeword");

  a_swrst_after: assert property (soft_reset_req |-> $past(r.state == sec_pkg::ST_FILL)
    && (r.state == sec_pkg::ST_IDLE) ##1 !soft_reset_req)
    else $error("soft reset outside end of scan fill");

  a_sbie_write: assert property ($rose(r.sbie) |-> $past(apb_wr && sel[`SEC_SEL_CTRL])
    && $past(pwdata[`SEC_CTRL_SBIE]))
    else $error("interrupt enable rose without software write");

  a_ecc_store: assert property ((r.state == sec_pkg::ST_IDLE) && mem_req && mem_we
    && (mem_be == `SEC_FULL_BE) && !r.init_en && (mem_addr[`SEC_OFF_W-1:2] <= `SEC_LAST_IDX)
    |-> wr_en && (wr_cw == cx.enc_cw) && (cx.enc_data == mem_wdata))
    else $error("full write did not store encoded word");

endmodule
`default_nettype wire

// >>> sec_core_model.sv
// core bus model making word and byte accesses on the sram port
`timescale 1ns/1ps
`default_nettype none
`include "sec_map.svh"
module sec_core_model (
  input  wire logic                   pclk,
  input  wire logic                   mem_ready,
  input  wire logic [`SEC_DATA_W-1:0] mem_rdata,
  output logic                        mem_req,
  output logic                        mem_we,
  output logic [3:0]                  mem_be,
  output logic [`SEC_OFF_W-1:0]       mem_addr,
  output logic [`SEC_DATA_W-1:0]      mem_wdata
);
  // quiet bus at time zero
  initial begin
    mem_req   = 1'b0;
    mem_we    = 1'b0;
    mem_be    = 4'h0;
    mem_addr  = 13'h0000;
    mem_wdata = 32'h0000_0000;
  end

  // hold the request until mem_ready is seen at an edge, then drop it
  task automatic xfer(input logic we, input logic [3:0] be, input logic [12:0] a,
                      input logic [31:0] d, output logic [31:0] r, output logic ok);
    int n;
    n = 0;
    @(posedge pclk);
    mem_req   <= 1'b1;
    mem_we    <= we;
    mem_be    <= be;
    mem_addr  <= a;
    mem_wdata <= d;
    do begin
      @(posedge pclk);
      n++;
    end while (mem_ready !== 1'b1 && n < 200);
    ok = (mem_ready === 1'b1);
    r = mem_rdata;
    // released byte enables, address and data show inverted junk, not the last value; mem_we keeps its last value
    mem_req   <= 1'b0;
    mem_be    <= ~be;
    mem_addr  <= ~a;
    mem_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// >>> sec_sram_ecc_controller_tb.sv
// self-checking bench of the sram ecc controller
`timescale 1ns/1ps
`default_nettype none
`include "sec_map.svh"
module sec_sram_ecc_controller_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, soft_reset_req;
  logic [31:0] paddr, pwdata, prdata, mem_rdata, mem_wdata;
  logic        mem_req, mem_we, mem_ready;
  logic [3:0]  mem_be;
  logic [12:0] mem_addr;
  logic [31:0] seed, r, x, d;
  logic [31:0] model [0:1535];
  logic        e;
  logic [10:0] idx;
  logic [3:0]  be;
  int          miscompares, checked, n, k;

  sec_sram_ecc_controller DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
    .mem_be(mem_be), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata), .irq(irq), .soft_reset_req(soft_reset_req));
  sec_core_model u_core (.pclk(pclk), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
    .mem_req(mem_req), .mem_we(mem_we), .mem_be(mem_be), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata));

  // clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // expected word after a byte-masked write
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
                                        input logic [3:0] m);
    for (int i = 0; i < 4; i++) begin
      if (m[i]) o[8*i +: 8] = w[8*i +: 8];
    end
    return o;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // apb transfer: setup, then access until pready at an edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    int c;
    c = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      c++;
    end while (pready !== 1'b1 && c < 50);
    check(pready, 1'b1, "apb ready");
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic mem(input logic we, input logic [3:0] m, input logic [12:0] a,
                     input logic [31:0] wd);
    logic ok;
    u_core.xfer(we, m, a, wd, r, ok);
    check(ok, 1'b1, "mem ready");
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #(40000 * 4);
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    seed = 32'h0000_3DD6;
    miscompares = 0;
    checked = 0;
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and unmapped place
    apb(0, `SEC_CTRL_ADDR, 0); check(r, 32'h0001, "ctrl reset");
    apb(0, `SEC_ERR_ADDR, 0); check(r, 32'h0, "errloc reset");
    apb(0, `SEC_STAT_ADDR, 0); check(r, 32'h0, "status reset");
    apb(0, 32'h4000_2040, 0); check(r, 32'h0, "unmapped data");
    check(e, 1'b1, "unmapped error");
    $display("test reset values done");
    // reserved bits and enable bit
    apb(1, `SEC_CTRL_ADDR, 32'h0000_FFFB);
    apb(0, `SEC_CTRL_ADDR, 0); check(r, 32'h0003, "ctrl reserved");
    apb(1, `SEC_CTRL_ADDR, 32'h0000_0001);
    apb(0, `SEC_CTRL_ADDR, 0); check(r, 32'h0001, "ctrl enable off");
    $display("test control bits done");
    // zero-fill, completion flag and interrupt
    apb(1, `SEC_CTRL_ADDR, 32'h0000_0005);
    apb(0, `SEC_CTRL_ADDR, 0); check(r[15], 1'b0, "done early");
    n = 0;
    do begin
      apb(0, `SEC_CTRL_ADDR, 0);
      n++;
    end while (r[15] !== 1'b1 && n < 3000);
    check(r, 32'h8001, "ctrl after fill");
    apb(0, `SEC_STAT_ADDR, 0); check(r, 32'h4, "fill status");
    apb(1, `SEC_MASK_ADDR, 32'h4); @(negedge pclk); check(irq, 1'b1, "irq on");
    apb(1, `SEC_MASK_ADDR, 32'h0); @(negedge pclk); check(irq, 1'b0, "irq masked");
    apb(1, `SEC_MASK_ADDR, 32'h4);
    apb(1, `SEC_STAT_ADDR, 32'h4); @(negedge pclk); check(irq, 1'b0, "irq cleared");
    apb(0, `SEC_STAT_ADDR, 0); check(r, 32'h0, "status w1c");
    $display("test zero-fill done");
    // memory: zero contents, random full and byte writes, read back
    for (int i = 0; i < 1536; i++) model[i] = 32'h0;
    mem(0, 4'hF, {`SEC_LAST_IDX, 2'b00}, 0); check(r, 32'h0, "zero last");
    for (k = 0; k < 24; k++) begin
      seed = xs(seed);
      x = seed % 32'd1536;
      idx = (k == 0) ? `SEC_LAST_IDX : x[10:0];
      seed = xs(seed);
      d = seed;
      be = (k < 12) ? 4'hF : d[7:4] ^ d[3:0];
      mem(1, be, {idx, 2'b00}, d);
      model[idx] = merge(model[idx], d, be);
      mem(0, 4'hF, {idx, 2'b00}, 0); check(r, model[idx], "read back");
    end
    $display("test memory done");
    // out of range offset: no write, zero data
    mem(1, 4'hF, 13'h1800, 32'hA5A5_5A5A);
    mem(0, 4'hF, 13'h1800, 0); check(r, 32'h0, "out of range");
    mem(0, 4'hF, 13'h0000, 0); check(r, model[0], "word 0 kept");
    // no faulty access: location and flags untouched
    apb(0, `SEC_ERR_ADDR, 0); check(r, 32'h0, "errloc clean");
    apb(0, `SEC_STAT_ADDR, 0); check(r, 32'h0, "no error flags");
    check(soft_reset_req, 1'b0, "no soft reset");
    $display("test range and flags done");
    // fault seeding: single error corrected and flagged, double error flagged
    apb(1, `SEC_CTRL_ADDR, 32'h0000_0003);
    apb(1, `SEC_MASK_ADDR, 32'h0000_0003);
    seed = xs(seed);
    d = seed;
    mem(1, 4'hF, 13'h001C, d);
    @(negedge pclk);
    DUT.mem[7] = DUT.mem[7] ^ 39'h00_0000_0200;
    mem(0, 4'hF, 13'h001C, 0); check(r, d, "single corrected");
    apb(0, `SEC_ERR_ADDR, 0); check(r, 32'h0000_001C, "errloc single");
    apb(0, `SEC_STAT_ADDR, 0); check(r, 32'h1, "single flag");
    @(negedge pclk); check(irq, 1'b1, "irq single");
    apb(1, `SEC_STAT_ADDR, 32'h1);
    apb(1, `SEC_CTRL_ADDR, 32'h0000_0001);
    mem(0, 4'hF, 13'h001C, 0); check(r, d, "corrected again");
    apb(0, `SEC_STAT_ADDR, 0); check(r, 32'h0, "single flag gated");
    @(negedge pclk);
    DUT.mem[9] = DUT.mem[9] ^ 39'h00_0010_0008;
    mem(0, 4'hF, 13'h0024, 0);
    apb(0, `SEC_STAT_ADDR, 0); check(r, 32'h2, "double flag");
    apb(0, `SEC_ERR_ADDR, 0); check(r, 32'h0000_0024, "errloc double");
    $display("test fault seeding done");
    // reset in mid-run: the scan finds the double error, zero-fills, pulses soft reset
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    while (soft_reset_req !== 1'b1 && n < 6000) begin
      @(posedge pclk);
      n++;
    end
    check(soft_reset_req, 1'b1, "soft reset after scan");
    apb(0, `SEC_CTRL_ADDR, 0); check(r, 32'h8001, "ctrl after scan fill");
    apb(0, `SEC_STAT_ADDR, 0); check(r, 32'h4, "scan fill status");
    apb(0, `SEC_ERR_ADDR, 0); check(r, 32'h0, "errloc after reset");
    mem(0, 4'hF, 13'h0024, 0); check(r, 32'h0, "double word zeroed");
    mem(0, 4'hF, 13'h001C, 0); check(r, 32'h0, "written word zeroed");
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
